// ==== ptc_defines.vh ====
// What this block does
// - translation enable is control word zero bit 31
// - large page extension is control word four bit 4
// - address extension is control word four bit 5
// - translation off means linear passes through
// - no large page or address extension: 4 KByte pages
// - 36-bit addresses only with translation on
// - address extension walks four-entry 64-bit pointer table
// - wide large page feature reported in bit 17
// - directory holds 1024 entries of 32 bits
// - table holds 1024 entries of 32 bits
// - large pages skip the table lookup
// - select bit picks table, 4M or 2M page
// - no extension: 4K or 4M, 32-bit address unless the wide feature widens 4M
// - extension on: 4K or 2M, 36-bit address
// - wide feature gives 36-bit 4M pages
// - linear bits 31..22 index the directory
// - linear bits 21..12 index the table
// - linear bits 11..0 are page offset
// - table base from directory, page from table
// - 4M page: bits 21..0 are offset
// - both extensions off: select bit ignored
// - directory found through directory base register
// - 4K entry base is top 20 bits
`ifndef PTC_DEFINES_VH
`define PTC_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PTC_OFS_CTL0      8'h00
`define PTC_OFS_CTL4      8'h04
`define PTC_OFS_DIRBASE   8'h08
`define PTC_OFS_LINEAR    8'h0c
`define PTC_OFS_STATUS    8'h10
`define PTC_OFS_PHYS_LO   8'h14
`define PTC_OFS_PHYS_HI   8'h18
`define PTC_OFS_QUERY_D   8'h1c

// ----------------------------------------
// field positions
// ----------------------------------------
`define PTC_BIT_ENABLE    31
`define PTC_BIT_LPE       4
`define PTC_BIT_AEXT      5
`define PTC_BIT_WIDE_FEAT 17
`define PTC_BIT_SELECT    7
`define PTC_BIT_ST_BUSY   0
`define PTC_BIT_ST_DONE   1
`define PTC_BIT_ST_WIDE   4

// ----------------------------------------
// reset values and page size codes
// ----------------------------------------
`define PTC_RST_CTL0      32'h0000_0000
`define PTC_RST_CTL4      32'h0000_0000
`define PTC_RST_DIRBASE   32'h0000_0000
`define PTC_SIZE_NONE     2'h0
`define PTC_SIZE_4K       2'h1
`define PTC_SIZE_4M       2'h2
`define PTC_SIZE_2M       2'h3

`endif

// ==== ptc_mode.v ====
`timescale 1ns/1ps
`include "ptc_defines.vh"

module ptc_mode
(
    input  wire       enable_in,
    input  wire       lpe_in,
    input  wire       aext_in,
    input  wire       select_in,
    input  wire       wide_feat_in,
    output reg  [1:0] size_out,
    output reg        wide_out
);

    always @*
    begin
        size_out = `PTC_SIZE_NONE;
        wide_out = 1'b0;
        if (!enable_in)
        begin
            size_out = `PTC_SIZE_NONE;
            wide_out = 1'b0;
        end
        else if (aext_in)
        begin
            size_out = select_in ? `PTC_SIZE_2M : `PTC_SIZE_4K;
            wide_out = 1'b1;
        end
        else if (lpe_in && select_in)
        begin
            size_out = `PTC_SIZE_4M;
            wide_out = wide_feat_in;
        end
        else
        begin
            // select bit has no say without either extension
            size_out = `PTC_SIZE_4K;
            wide_out = 1'b0;
        end
    end

endmodule // ptc_mode

// ==== ptc_top.v ====
`timescale 1ns/1ps
`include "ptc_defines.vh"

module ptc_top
#(
    parameter WIDE_FEAT = 1
)
(
    input  wire        clk_sys_in,
    input  wire        rstn_in,
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output wire        hreadyout_out,
    output wire        hresp_out,
    output reg  [31:0] hrdata_out,
    output reg         mem_req_out,
    output reg  [35:0] mem_addr_out,
    output reg         mem_wide_out,
    input  wire        mem_ack_in,
    input  wire [63:0] mem_rdata_in,
    output wire        busy_out,
    output reg         done_out
);

    // ----------------------------------------
    // walk states
    // ----------------------------------------
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_PTR  = 4'b0010;
    localparam [3:0] S_DIR  = 4'b0100;
    localparam [3:0] S_TBL  = 4'b1000;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    reg  [31:0] ctl0;
    reg  [31:0] ctl4;
    reg  [31:0] dirbase;
    reg  [31:0] linear;
    reg  [35:0] phys;
    reg  [1:0]  page_size;
    reg         phys_wide;
    reg  [3:0]  state;
    reg         walk_enable;
    reg         walk_aext;
    reg         walk_lpe;

    reg         dp_valid;
    reg         dp_write;
    reg  [7:0]  dp_addr;

    wire        bus_take;
    wire        start;
    wire        enable;
    wire        lpe;
    wire        aext;
    wire [1:0]  mode_size;
    wire        mode_wide;
    wire [31:0] query_d;
    wire [31:0] status_word;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // entry address: base plus index scaled by 4 or 8 bytes
    function [35:0] ent_addr;
        input [35:0] base;
        input [9:0]  idx;
        input        wide;
        begin
            if (wide)
                ent_addr = base + {23'h0, idx, 3'h0};
            else
                ent_addr = base + {24'h0, idx, 2'h0};
        end
    endfunction

    // base of the next table or page from an entry; a narrow entry keeps
    // only its top 20 bits, so tables and pages stay 4 KByte aligned
    function [35:0] ent_base;
        input [63:0] ent;
        input        wide;
        begin
            if (wide)
                ent_base = {ent[35:12], 12'h0};
            else
                ent_base = {4'h0, ent[31:12], 12'h0};
        end
    endfunction

    // entry index at one level of the walk: two bits into the pointer
    // table, nine into a wide directory or table, ten into a narrow one
    function [9:0] lin_index;
        input [31:0] lin;
        input [3:0]  level;
        input        wide;
        begin
            case (level)
                S_PTR:   lin_index = {8'h0, lin[31:30]};
                S_DIR:   lin_index = wide ? {1'b0, lin[29:21]} : lin[31:22];
                S_TBL:   lin_index = wide ? {1'b0, lin[20:12]} : lin[21:12];
                default: lin_index = 10'h0;
            endcase
        end
    endfunction

    // registers alias every 256 bytes and ignore the byte lanes
    function [7:0] word_ofs;
        input [31:0] addr;
        begin
            word_ofs = {addr[7:2], 2'h0};
        end
    endfunction

    function [31:0] read_mux;
        input [7:0] ofs;
        begin
            case (ofs)
                `PTC_OFS_CTL0:    read_mux = ctl0;
                `PTC_OFS_CTL4:    read_mux = ctl4;
                `PTC_OFS_DIRBASE: read_mux = dirbase;
                `PTC_OFS_LINEAR:  read_mux = linear;
                `PTC_OFS_STATUS:  read_mux = status_word;
                `PTC_OFS_PHYS_LO: read_mux = phys[31:0];
                `PTC_OFS_PHYS_HI: read_mux = {28'h0, phys[35:32]};
                `PTC_OFS_QUERY_D: read_mux = query_d;
                default:          read_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    assign enable = ctl0[`PTC_BIT_ENABLE];
    assign lpe    = ctl4[`PTC_BIT_LPE];
    assign aext   = ctl4[`PTC_BIT_AEXT];

    assign query_d = (WIDE_FEAT != 0) ? (32'h1 << `PTC_BIT_WIDE_FEAT) : 32'h0;

    assign status_word = {27'h0, phys_wide, page_size, done_out, busy_out};
    assign busy_out    = (state != S_IDLE);

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------
    // zero wait states, always okay; unmapped reads give zero
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign bus_take      = hsel_in && htrans_in[1] && hready_in;

    always @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            dp_valid   <= 1'b0;
            dp_write   <= 1'b0;
            dp_addr    <= 8'h00;
            hrdata_out <= 32'h0000_0000;
        end
        else
        begin
            dp_valid <= bus_take;
            dp_write <= hwrite_in;
            dp_addr  <= word_ofs(haddr_in);
            // read data is sampled at the address phase, so a write in
            // the previous data phase to the same word is not yet seen
            if (bus_take && !hwrite_in)
                hrdata_out <= read_mux(word_ofs(haddr_in));
        end
    end

    // a new linear address only starts a walk while idle
    assign start = dp_valid && dp_write && (dp_addr == `PTC_OFS_LINEAR) && !busy_out;

    always @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ctl0    <= `PTC_RST_CTL0;
            ctl4    <= `PTC_RST_CTL4;
            dirbase <= `PTC_RST_DIRBASE;
            linear  <= 32'h0000_0000;
        end
        else if (dp_valid && dp_write)
        begin
            case (dp_addr)
                `PTC_OFS_CTL0:    ctl0    <= hwdata_in & (32'h1 << `PTC_BIT_ENABLE);
                `PTC_OFS_CTL4:    ctl4    <= hwdata_in & ((32'h1 << `PTC_BIT_LPE)
                                                        | (32'h1 << `PTC_BIT_AEXT));
                `PTC_OFS_DIRBASE: dirbase <= hwdata_in;
                `PTC_OFS_LINEAR:
                begin
                    if (!busy_out)
                        linear <= hwdata_in;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // page size decode
    // ----------------------------------------
    // flags are frozen at start; a change mid-walk applies to the next one
    ptc_mode u_mode
    (
        .enable_in    (walk_enable),
        .lpe_in       (walk_lpe),
        .aext_in      (walk_aext),
        .select_in    (mem_rdata_in[`PTC_BIT_SELECT]),
        .wide_feat_in (WIDE_FEAT != 0),
        .size_out     (mode_size),
        .wide_out     (mode_wide)
    );

    // ----------------------------------------
    // table walk
    // ----------------------------------------
    always @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state         <= S_IDLE;
            mem_req_out   <= 1'b0;
            mem_addr_out  <= 36'h0;
            mem_wide_out  <= 1'b0;
            phys          <= 36'h0;
            page_size     <= `PTC_SIZE_NONE;
            phys_wide     <= 1'b0;
            done_out      <= 1'b0;
            walk_enable   <= 1'b0;
            walk_aext     <= 1'b0;
            walk_lpe      <= 1'b0;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (start)
                    begin
                        done_out    <= 1'b0;
                        walk_enable <= enable;
                        walk_aext   <= aext;
                        walk_lpe    <= lpe;
                        if (!enable)
                        begin
                            phys      <= {4'h0, hwdata_in};
                            page_size <= `PTC_SIZE_NONE;
                            phys_wide <= 1'b0;
                            done_out  <= 1'b1;
                        end
                        else if (aext)
                        begin
                            // pointer table is 32-byte aligned, four entries
                            mem_addr_out <= ent_addr({4'h0, dirbase[31:5], 5'h0},
                                                     lin_index(hwdata_in, S_PTR, 1'b1), 1'b1);
                            mem_wide_out <= 1'b1;
                            mem_req_out  <= 1'b1;
                            state        <= S_PTR;
                        end
                        else
                        begin
                            mem_addr_out <= ent_addr(ent_base({32'h0, dirbase}, 1'b0),
                                                     lin_index(hwdata_in, S_DIR, 1'b0), 1'b0);
                            mem_wide_out <= 1'b0;
                            mem_req_out  <= 1'b1;
                            state        <= S_DIR;
                        end
                    end
                end
                S_PTR:
                begin
                    if (mem_ack_in)
                    begin
                        mem_addr_out <= ent_addr(ent_base(mem_rdata_in, 1'b1),
                                                 lin_index(linear, S_DIR, 1'b1), 1'b1);
                        state        <= S_DIR;
                    end
                end
                S_DIR:
                begin
                    if (mem_ack_in)
                    begin
                        phys_wide <= mode_wide;
                        page_size <= mode_size;
                        if (mode_size == `PTC_SIZE_4M)
                        begin
                            // no table lookup for large pages
                            mem_req_out <= 1'b0;
                            phys        <= {mode_wide ? mem_rdata_in[16:13] : 4'h0,
                                            mem_rdata_in[31:22], linear[21:0]};
                            done_out    <= 1'b1;
                            state       <= S_IDLE;
                        end
                        else if (mode_size == `PTC_SIZE_2M)
                        begin
                            mem_req_out <= 1'b0;
                            phys        <= {mem_rdata_in[35:21], linear[20:0]};
                            done_out    <= 1'b1;
                            state       <= S_IDLE;
                        end
                        else if (walk_aext)
                        begin
                            mem_addr_out <= ent_addr(ent_base(mem_rdata_in, 1'b1),
                                                     lin_index(linear, S_TBL, 1'b1), 1'b1);
                            state        <= S_TBL;
                        end
                        else
                        begin
                            mem_addr_out <= ent_addr(ent_base(mem_rdata_in, 1'b0),
                                                     lin_index(linear, S_TBL, 1'b0), 1'b0);
                            state        <= S_TBL;
                        end
                    end
                end
                S_TBL:
                begin
                    if (mem_ack_in)
                    begin
                        mem_req_out <= 1'b0;
                        if (walk_aext)
                            phys <= {mem_rdata_in[35:12], linear[11:0]};
                        else
                            phys <= {4'h0, mem_rdata_in[31:12], linear[11:0]};
                        done_out <= 1'b1;
                        state    <= S_IDLE;
                    end
                end
                default:
                begin
                    state       <= S_IDLE;
                    mem_req_out <= 1'b0;
                end
            endcase
        end
    end

endmodule // ptc_top

// ==== ptc_assertions.sv ====
`timescale 1ns/1ps
module ptc_assertions
(
    input wire        clk_sys_in,
    input wire        rstn_in,
    input wire        hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0]  htrans_in,
    input wire        hwrite_in,
    input wire [31:0] hwdata_in,
    input wire        hready_in,
    input wire        mem_req_out,
    input wire [35:0] mem_addr_out,
    input wire        mem_wide_out,
    input wire        mem_ack_in,
    input wire        busy_out,
    input wire        done_out
);
    // ----------------------------------------
    // shadow of the linear address, kept only for accepted starts
    // ----------------------------------------
    logic        lin_wr;
    logic [31:0] lin;
    always @(posedge clk_sys_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            lin_wr <= 1'b0;
            lin    <= 32'h0;
        end
        else if (hready_in)
        begin
            lin_wr <= hsel_in && htrans_in[1] && hwrite_in && haddr_in[7:2] == 6'h03;
            if (lin_wr && !busy_out)
                lin <= hwdata_in;
        end
    end
    // ----------------------------------------
    // walk properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_req_held: assert property (mem_req_out && !mem_ack_in |=> mem_req_out)
        else $error("walk request dropped before answer");
    a_addr_stable: assert property (mem_req_out && !mem_ack_in |=> $stable(mem_addr_out))
        else $error("walk address moved while waiting");
    a_req_busy: assert property (mem_req_out |-> busy_out)
        else $error("memory request outside a walk");
    a_done_idle: assert property (done_out |-> !busy_out)
        else $error("done shown during a walk");
    a_dir_index: assert property ($rose(mem_req_out) && !mem_wide_out |-> mem_addr_out[11:0] == {lin[31:22], 2'b00})
        else $error("directory index wrong");
    a_tbl_index: assert property (mem_ack_in && mem_req_out && !mem_wide_out
        |=> !mem_req_out || mem_addr_out[11:0] == {lin[21:12], 2'b00})
        else $error("table index wrong");
    a_ptr_index: assert property ($rose(mem_req_out) && mem_wide_out |-> mem_addr_out[4:0] == {lin[31:30], 3'b000})
        else $error("pointer table index wrong");
    a_walk_bound: assert property ($rose(busy_out) |-> ##[1:60] $rose(done_out))
        else $error("walk did not finish in time");
    cover property ($rose(mem_req_out) && mem_wide_out);
    cover property ($rose(done_out));
    cover property (mem_req_out && !mem_ack_in ##1 mem_req_out);
endmodule // ptc_assertions

// ==== ptc_mem_model.sv ====
`timescale 1ns/1ps
module ptc_mem_model
(
    input  wire         clk_in,
    input  wire         rstn_in,
    input  wire         req_in,
    input  wire  [35:0] addr_in,
    input  wire  [3:0]  delay_in,
    output logic        ack_out,
    output logic [63:0] rdata_out
);
    // ----------------------------------------
    // entry store, unwritten places read as zero
    // ----------------------------------------
    logic [63:0] mem [logic [35:0]];
    logic [3:0]  wait_cnt;
    // data lines churn between answers so a stale entry is never taken as fresh
    always @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ack_out   <= 1'b0;
            wait_cnt  <= 4'h0;
            rdata_out <= 64'h5a5a_5a5a_a5a5_a5a5;
        end
        else if (req_in && !ack_out && wait_cnt == delay_in)
        begin
            ack_out   <= 1'b1;
            wait_cnt  <= 4'h0;
            rdata_out <= mem.exists(addr_in) ? mem[addr_in] : 64'h0;
        end
        else
        begin
            ack_out   <= 1'b0;
            wait_cnt  <= (req_in && !ack_out) ? wait_cnt + 4'h1 : 4'h0;
            rdata_out <= ~rdata_out;
        end
    end
endmodule // ptc_mem_model

// ==== ptc_tb.sv ====
`timescale 1ns/1ps
module testbench;
    localparam WIDE = 1;
    logic        clk_sys_in, rstn_in, hwrite_in;
    logic [31:0] haddr_in, hwdata_in;
    logic [1:0]  htrans_in;
    logic [3:0]  delay;
    wire         hready_in, hreadyout_out, hresp_out, mem_req_out, mem_wide_out, mem_ack_in, busy_out, done_out;
    wire  [31:0] hrdata_out;
    wire  [35:0] mem_addr_out;
    wire  [63:0] mem_rdata_in;
    int          errors, comparisons;
    logic [31:0] lin, dirbase;
    logic [63:0] ptr, directory_entry, table_entry;
    assign hready_in = hreadyout_out;
    ptc_top #(.WIDE_FEAT(WIDE)) ptc_top_i (.clk_sys_in, .rstn_in, .hsel_in(1'b1), .haddr_in, .htrans_in,
        .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .hrdata_out,
        .mem_req_out, .mem_addr_out, .mem_wide_out, .mem_ack_in, .mem_rdata_in, .busy_out, .done_out);
    ptc_mem_model ptc_mem_model_i (.clk_in(clk_sys_in), .rstn_in, .req_in(mem_req_out), .addr_in(mem_addr_out),
        .delay_in(delay), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
    // ----------------------------------------
    // bus cycles and comparisons
    // ----------------------------------------
    task automatic check(input string nm, input [31:0] exp, input [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input [7:0] a, input w, input [31:0] wd, output [31:0] rd);
        htrans_in <= 2'h2;
        haddr_in  <= {24'h0, a};
        hwrite_in <= w;
        do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic rchk(input string nm, input [7:0] a, input [31:0] exp);
        logic [31:0] x;
        bus(a, 1'b0, 32'h0, x);
        check(nm, exp, x);
        check("hresp", 32'h0, {31'h0, hresp_out});
    endtask
    task automatic put(input [35:0] a, input [63:0] d);
        ptc_mem_model_i.mem[a] = d;
    endtask
    // a second start while busy must be ignored, so dup fires one mid-walk
    task automatic xlate(input [31:0] l, input dup, input [35:0] exp, input [1:0] sz, input ew);
        logic [31:0] s;
        wr(8'h0c, l);
        if (dup)
            wr(8'h0c, ~l);
        s = 32'h0;
        while (s[1] !== 1'b1)
            bus(8'h10, 1'b0, 32'h0, s);
        check("page size", {30'h0, sz}, {30'h0, s[3:2]});
        check("wide", {31'h0, ew}, {31'h0, s[4]});
        check("done pin", 32'h1, {31'h0, done_out});
        rchk("phys low", 8'h14, exp[31:0]);
        rchk("phys high", 8'h18, {28'h0, exp[35:32]});
        rchk("linear kept", 8'h0c, l);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rchk("ctl0 reset", 8'h00, 32'h0);
        rchk("ctl4 reset", 8'h04, 32'h0);
        rchk("dir base reset", 8'h08, 32'h0);
        rchk("query d", 8'h1c, WIDE << 17);
        wr(8'h00, 32'hffff_ffff);
        rchk("ctl0 enable", 8'h00, 32'h8000_0000);
        wr(8'h04, 32'hffff_ffff);
        rchk("ctl4 flags", 8'h04, 32'h0000_0030);
        wr(8'h24, 32'hffff_ffff);
        rchk("unmapped", 8'h24, 32'h0);
    endtask
    task automatic t_off;
        wr(8'h00, 32'h0);
        xlate(32'hfedc_ba98, 1'b0, 36'h0_fedc_ba98, 2'h0, 1'b0);
    endtask
    task automatic t_small;
        dirbase = 32'h0001_2000;
        lin = 32'habcd_e123;
        directory_entry = 64'h0003_4087;
        table_entry = 64'h0005_6003;
        put({dirbase[31:12], lin[31:22], 2'b00}, directory_entry);
        put({directory_entry[31:12], lin[21:12], 2'b00}, table_entry);
        wr(8'h08, dirbase);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h8000_0000);
        delay = 4'h0;
        xlate(lin, 1'b0, {4'h0, table_entry[31:12], lin[11:0]}, 2'h1, 1'b0);
        wr(8'h04, 32'h10);
        delay = 4'h2;
        xlate(lin, 1'b0, {WIDE ? directory_entry[16:13] : 4'h0, directory_entry[31:22], lin[21:0]}, 2'h2, WIDE != 0);
    endtask
    task automatic t_ext;
        dirbase = 32'h0001_2060;
        lin = 32'hc0a5_5123;
        ptr = 64'h0000_0002_0003_0001;
        directory_entry = 64'h0000_0009_0004_5003;
        table_entry = 64'h0000_000c_0bcd_0001;
        put({dirbase[31:5], lin[31:30], 3'b000}, ptr);
        put({ptr[35:12], lin[29:21], 3'b000}, directory_entry);
        put({directory_entry[35:12], lin[20:12], 3'b000}, table_entry);
        wr(8'h08, dirbase);
        wr(8'h04, 32'h20);
        delay = 4'h3;
        xlate(lin, 1'b1, {table_entry[35:12], lin[11:0]}, 2'h1, 1'b1);
        directory_entry = 64'h0000_0007_0060_0083;
        put({ptr[35:12], lin[29:21], 3'b000}, directory_entry);
        wr(8'h04, 32'h30);
        xlate(lin, 1'b0, {directory_entry[35:21], lin[20:0]}, 2'h3, 1'b1);
    endtask
    // a reset in mid-run drops the enables and the sticky done
    task automatic t_reset;
        rstn_in <= 1'b0;
        @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        check("done after reset", 32'h0, {31'h0, done_out});
        rchk("ctl0 after reset", 8'h00, 32'h0);
        rchk("ctl4 after reset", 8'h04, 32'h0);
        rchk("status after reset", 8'h10, 32'h0);
    endtask
    // ----------------------------------------
    // verdict, clock, sequence and watchdog
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        rstn_in = 1'b0;
        htrans_in = 2'h0;
        haddr_in = 32'h0;
        hwrite_in = 1'b0;
        hwdata_in = 32'h0;
        delay = 4'h0;
        repeat (2) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        t_regs();
        t_off();
        t_small();
        t_ext();
        t_reset();
        tally_and_finish();
    end
    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #(20 * 5000);
        errors++;
        tally_and_finish();
    end
endmodule // testbench
bind ptc_top ptc_assertions ptc_assertions_i (.clk_sys_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hwdata_in, .hready_in, .mem_req_out, .mem_addr_out, .mem_wide_out, .mem_ack_in, .busy_out, .done_out);
